/* core/uefg_regs.vh */
// constants for the enhanced uart control block: register indices, fields, reset values
// assumes the register port is a byte-wide internal port with index, read and write strobes
`ifndef UEFG_REGS_VH
`define UEFG_REGS_VH
`define UEFG_A_SCRATCH   5'h07
`define UEFG_A_FCR       5'h02
`define UEFG_A_MCR       5'h04
`define UEFG_A_DLL       5'h00
`define UEFG_A_DLM       5'h01
`define UEFG_A_TX_FIFO_FREE_COUNT     5'h08
`define UEFG_A_RX_FIFO_FILL_COUNT     5'h09
`define UEFG_A_PIN_DIRECTION     5'h0a
`define UEFG_A_PIN_STATE   5'h0b
`define UEFG_A_PIN_INTERRUPT_ENABLE  5'h0c
`define UEFG_A_IOCTRL    5'h0e
`define UEFG_A_EXTRA_FEATURE_CONTROL      5'h0f
`define UEFG_A_DLD       5'h12
`define UEFG_A_EFR       5'h13
`define UEFG_A_TXDATA    5'h14
`define UEFG_A_RXDATA    5'h15
`define UEFG_A_TIMEOUT   5'h16
`define UEFG_EFR_ENH     4
`define UEFG_MCR_TCRTLR  2
`define UEFG_IOC_SRESET  3
`define UEFG_IOC_LATCH   0
`define UEFG_EXTRA_FEATURE_CONTROL_TXDIS  2
`define UEFG_EXTRA_FEATURE_CONTROL_RXDIS  1
`define UEFG_RST_DLL     8'h01
`define UEFG_RST_ZERO    8'h00
`define UEFG_RST_SCRATCH 8'hff
`define UEFG_FIFO_DEPTH  7'h40
`define UEFG_TIMEOUT_BITS 8'h28
`endif

/* core/uefg_core.v */
// enhanced uart control: fifo levels and triggers, gpio, soft reset, tx/rx disable, divisor
// assumes a synchronous byte register port on clk, and gpio pins asynchronous to clk
// Notes on behaviour
// - tx ready when free entries reach trigger field times four
// - zero tx trigger field falls back to fifo control bits 5:4
// - rx ready when stored count reaches upper trigger field times four
// - zero rx trigger field falls back to fifo control bits 7:6
// - rx timeout when fifo non-empty and line idle for timeout period
// - level registers report free tx entries and stored rx characters
// - low pin direction bits set each gpio as output or input
// - state reads give input levels; writes drive output pins
// - interrupt enable bits allow input changes to interrupt
// - control bit 3 write causes software reset then self-clears
// - unlatched: change interrupts; read or reverting pin clears it
// - latched: change interrupts and captures value; only read clears
// - tx disable stops output after current character; fifo still fills
// - rx disable stops reception at once; current character completes
// - divisor is high:low bytes plus fraction/16; fraction needs enhanced enable
// - fraction bits 5:4 pick 16x, 8x or 4x sampling
// - enhanced bits 3:2 select transmit flow characters
// - enhanced bits 1:0 select receive comparison mode
// - enhanced bit 4 gates writes to enhanced bits and registers
// - trigger register shares scratch address when enhanced and selected
`timescale 1ns/100ps
`default_nettype none
`include "uefg_regs.vh"
module uefg_core #(
  parameter DEPTH_W = 7,
  parameter NGPIO   = 4
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [4:0]       reg_index,
  input  wire             reg_wr,
  input  wire             reg_rd,
  input  wire [7:0]       reg_wdata,
  output reg  [7:0]       reg_rdata_ff,
  input  wire             tx_push,
  input  wire             tx_pop,
  input  wire             rx_push,
  input  wire             rx_pop,
  input  wire             rx_line_busy,
  input  wire             tx_char_active,
  input  wire             rx_char_active,
  input  wire             baud_tick,
  input  wire [NGPIO-1:0] gpio_in,
  output reg  [NGPIO-1:0] gpio_out_ff,
  output reg  [NGPIO-1:0] gpio_oe_ff,
  output reg              tx_ready_irq_ff,
  output reg              rx_ready_irq_ff,
  output reg              rx_timeout_irq_ff,
  output reg              irq_n_ff,
  output reg              tx_run_ff,
  output reg              rx_run_ff,
  output reg  [15:0]      divisor_int_ff,
  output reg  [3:0]       divisor_frac_ff,
  output reg  [1:0]       sample_mode_ff,
  output reg  [1:0]       tx_flow_sel_ff,
  output reg  [1:0]       rx_flow_sel_ff,
  output reg              soft_reset_ff
);
  // ========================================
  // registers
  reg [7:0]         trig_ff;
  reg [7:0]         fcr_ff;
  reg [7:0]         mcr_ff;
  reg [7:0]         scratch_ff;
  reg [7:0]         pin_direction_ff;
  reg [7:0]         pin_state_ff;
  reg [7:0]         ioint_ff;
  reg [7:0]         ioctl_ff;
  reg [7:0]         extra_feature_control_ff;
  reg [7:0]         dll_ff;
  reg [7:0]         dlm_ff;
  reg [7:0]         dld_ff;
  reg [7:0]         efr_ff;
  reg [DEPTH_W-1:0] tx_cnt_ff;
  reg [DEPTH_W-1:0] rx_cnt_ff;
  reg [NGPIO-1:0]   sync1_ff;
  reg [NGPIO-1:0]   sync2_ff;
  reg [NGPIO-1:0]   ref_ff;
  reg [NGPIO-1:0]   pend_ff;
  reg [NGPIO-1:0]   cap_ff;
  reg [7:0]       idle_ff;

  wire            any_rst = reset | soft_reset_ff;
  wire            enh     = efr_ff[`UEFG_EFR_ENH];
  wire            wr_en   = reg_wr;
  wire            tlr_sel = enh & mcr_ff[`UEFG_MCR_TCRTLR];
  wire [DEPTH_W-1:0] tx_free = `UEFG_FIFO_DEPTH - tx_cnt_ff;

  // ========================================
  // trigger selection
  function [DEPTH_W-1:0] trig_level;
    input [3:0] field;
    input [1:0] legacy;
    input       is_tx;
    begin
      if (field != 4'h0) begin
        trig_level = {1'b0, field, 2'b00};
      end else begin
        case (legacy)
          2'b00:   trig_level = is_tx ? 7'h08 : 7'h08;
          2'b01:   trig_level = is_tx ? 7'h10 : 7'h10;
          2'b10:   trig_level = is_tx ? 7'h20 : 7'h38;
          default: trig_level = is_tx ? 7'h38 : 7'h3c;
        endcase
      end
    end
  endfunction

  wire [DEPTH_W-1:0] tx_trig = trig_level(trig_ff[3:0], fcr_ff[5:4], 1'b1);
  wire [DEPTH_W-1:0] rx_trig = trig_level(trig_ff[7:4], fcr_ff[7:6], 1'b0);

  // ========================================
  // gpio input view
  wire [NGPIO-1:0] pin_view = ioctl_ff[`UEFG_IOC_LATCH] ? cap_ff : sync2_ff;
  wire [NGPIO-1:0] state_rd = (pin_direction_ff[NGPIO-1:0] & pin_state_ff[NGPIO-1:0]) |
                              (~pin_direction_ff[NGPIO-1:0] & pin_view);
  wire st_read = reg_rd & (reg_index == `UEFG_A_PIN_STATE);
  wire [NGPIO-1:0] change = (sync2_ff ^ ref_ff) & ~pin_direction_ff[NGPIO-1:0];
  // a pending latched bit keeps its first captured value until it is read
  wire [NGPIO-1:0] fresh  = change & ~(pend_ff & ~{NGPIO{st_read}});

  // ========================================
  // fifo count step, shared by both directions
  function [DEPTH_W-1:0] cnt_next;
    input [DEPTH_W-1:0] cnt;
    input               push;
    input               pop;
    reg                 do_push;
    reg                 do_pop;
    begin
      // events on a full or empty fifo are dropped rather than wrapping the count
      do_push = push && (cnt != `UEFG_FIFO_DEPTH);
      do_pop  = pop && (cnt != {DEPTH_W{1'b0}});
      if (do_push && !do_pop) begin
        cnt_next = cnt + 7'h01;
      end else if (do_pop && !do_push) begin
        cnt_next = cnt - 7'h01;
      end else begin
        cnt_next = cnt;
      end
    end
  endfunction

  // ========================================
  // register writes
  always @(posedge clk) begin
    if (any_rst) begin
      trig_ff       <= `UEFG_RST_ZERO;
      fcr_ff        <= `UEFG_RST_ZERO;
      mcr_ff        <= `UEFG_RST_ZERO;
      pin_direction_ff      <= `UEFG_RST_ZERO;
      pin_state_ff    <= `UEFG_RST_ZERO;
      ioint_ff      <= `UEFG_RST_ZERO;
      ioctl_ff      <= `UEFG_RST_ZERO;
      extra_feature_control_ff       <= `UEFG_RST_ZERO;
      dld_ff        <= `UEFG_RST_ZERO;
      efr_ff        <= `UEFG_RST_ZERO;
      soft_reset_ff <= 1'b0;
    end else begin
      soft_reset_ff <= 1'b0;
      if (wr_en) begin
        case (reg_index)
          `UEFG_A_FCR: fcr_ff <= enh ? reg_wdata : {reg_wdata[7:6], fcr_ff[5:4], reg_wdata[3:0]};
          `UEFG_A_MCR: mcr_ff <= enh ? reg_wdata : {mcr_ff[7:5], reg_wdata[4:3], mcr_ff[2], reg_wdata[1:0]};
          `UEFG_A_SCRATCH: if (tlr_sel) trig_ff <= reg_wdata;
          `UEFG_A_PIN_DIRECTION:    pin_direction_ff   <= reg_wdata;
          `UEFG_A_PIN_STATE:  pin_state_ff <= {4'h0, reg_wdata[3:0]};
          `UEFG_A_PIN_INTERRUPT_ENABLE: ioint_ff   <= reg_wdata;
          `UEFG_A_IOCTRL: begin
            ioctl_ff      <= {5'h00, reg_wdata[2:0]};
            soft_reset_ff <= reg_wdata[`UEFG_IOC_SRESET];
          end
          `UEFG_A_EXTRA_FEATURE_CONTROL: extra_feature_control_ff <= {5'h00, reg_wdata[2:1], 1'b0};
          `UEFG_A_DLD:  if (enh) dld_ff <= {2'b00, reg_wdata[5:0]};
          `UEFG_A_EFR:  efr_ff <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // divisor bytes keep their values over the soft reset; only the pin reset reloads them
  always @(posedge clk) begin
    if (reset) begin
      dll_ff     <= `UEFG_RST_DLL;
      dlm_ff     <= `UEFG_RST_ZERO;
      scratch_ff <= `UEFG_RST_SCRATCH;
    end else if (wr_en) begin
      if (reg_index == `UEFG_A_DLL) dll_ff <= reg_wdata;
      if (reg_index == `UEFG_A_DLM) dlm_ff <= reg_wdata;
      if (reg_index == `UEFG_A_SCRATCH && !tlr_sel) scratch_ff <= reg_wdata;
    end
  end

  // ========================================
  // fifo occupancy
  always @(posedge clk) begin
    if (any_rst) begin
      tx_cnt_ff <= {DEPTH_W{1'b0}};
      rx_cnt_ff <= {DEPTH_W{1'b0}};
    end else begin
      // tx pushes are taken while disabled too, until full
      tx_cnt_ff <= cnt_next(tx_cnt_ff, tx_push, tx_pop);
      // a character already underway still lands after rx disable
      rx_cnt_ff <= cnt_next(rx_cnt_ff, rx_push, rx_pop);
    end
  end

  // ========================================
  // status, idle timer, control outputs
  always @(posedge clk) begin
    if (any_rst) begin
      idle_ff           <= 8'h00;
      tx_ready_irq_ff   <= 1'b0;
      rx_ready_irq_ff   <= 1'b0;
      rx_timeout_irq_ff <= 1'b0;
      tx_run_ff         <= 1'b1;
      rx_run_ff         <= 1'b1;
      divisor_int_ff    <= 16'h0001;
      divisor_frac_ff   <= 4'h0;
      sample_mode_ff    <= 2'b00;
      tx_flow_sel_ff    <= 2'b00;
      rx_flow_sel_ff    <= 2'b00;
    end else begin
      if (rx_line_busy || rx_cnt_ff == 0 || rx_pop)
        idle_ff <= 8'h00;
      else if (baud_tick && idle_ff != `UEFG_TIMEOUT_BITS)
        idle_ff <= idle_ff + 8'h01;
      tx_ready_irq_ff   <= tx_free >= tx_trig;
      rx_ready_irq_ff   <= rx_cnt_ff >= rx_trig;
      rx_timeout_irq_ff <= rx_cnt_ff != 0 && idle_ff == `UEFG_TIMEOUT_BITS;
      // disable takes effect only between characters on tx; on rx, run is held high while a character is active
      if (!tx_char_active) tx_run_ff <= ~extra_feature_control_ff[`UEFG_EXTRA_FEATURE_CONTROL_TXDIS];
      rx_run_ff <= ~extra_feature_control_ff[`UEFG_EXTRA_FEATURE_CONTROL_RXDIS] | rx_char_active;
      divisor_int_ff  <= {dlm_ff, dll_ff};
      divisor_frac_ff <= dld_ff[3:0];
      sample_mode_ff  <= dld_ff[5] ? 2'b10 : {1'b0, dld_ff[4]};
      tx_flow_sel_ff  <= efr_ff[3:2];
      rx_flow_sel_ff  <= efr_ff[1:0];
    end
  end

  // ========================================
  // gpio pins and change interrupts
  always @(posedge clk) begin
    if (any_rst) begin
      sync1_ff    <= {NGPIO{1'b0}};
      sync2_ff    <= {NGPIO{1'b0}};
      ref_ff      <= {NGPIO{1'b0}};
      pend_ff     <= {NGPIO{1'b0}};
      cap_ff      <= {NGPIO{1'b0}};
      gpio_out_ff <= {NGPIO{1'b0}};
      gpio_oe_ff  <= {NGPIO{1'b0}};
      irq_n_ff    <= 1'b1;
    end else begin
      sync1_ff    <= gpio_in;
      sync2_ff    <= sync1_ff;
      gpio_oe_ff  <= pin_direction_ff[NGPIO-1:0];
      gpio_out_ff <= pin_state_ff[NGPIO-1:0];
      if (ioctl_ff[`UEFG_IOC_LATCH]) begin
        // latched: new change sets and captures; read clears, set wins over read
        pend_ff <= (pend_ff & ~{NGPIO{st_read}}) | change;
        cap_ff  <= (cap_ff & ~fresh) | (sync2_ff & fresh);
        ref_ff  <= ref_ff ^ change;
      end else begin
        // unlatched: pending tracks mismatch against the level seen at last read
        // a read clears, unless the pin is moving again in the same cycle
        pend_ff <= st_read ? (change & (sync2_ff ^ sync1_ff)) : change;
        cap_ff  <= sync2_ff;
        if (st_read) ref_ff <= sync2_ff;
      end
      irq_n_ff <= ~|(pend_ff & ioint_ff[NGPIO-1:0]);
    end
  end

  // ========================================
  // register reads
  always @(posedge clk) begin
    if (any_rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_index)
        `UEFG_A_FCR:      reg_rdata_ff <= fcr_ff;
        `UEFG_A_MCR:      reg_rdata_ff <= mcr_ff;
        `UEFG_A_SCRATCH:  reg_rdata_ff <= tlr_sel ? trig_ff : scratch_ff;
        `UEFG_A_TX_FIFO_FREE_COUNT:    reg_rdata_ff <= {1'b0, tx_free};
        `UEFG_A_RX_FIFO_FILL_COUNT:    reg_rdata_ff <= {1'b0, rx_cnt_ff};
        `UEFG_A_PIN_DIRECTION:    reg_rdata_ff <= pin_direction_ff;
        `UEFG_A_PIN_STATE:  reg_rdata_ff <= {4'h0, state_rd};
        `UEFG_A_PIN_INTERRUPT_ENABLE: reg_rdata_ff <= ioint_ff;
        `UEFG_A_IOCTRL:   reg_rdata_ff <= ioctl_ff;
        `UEFG_A_EXTRA_FEATURE_CONTROL:     reg_rdata_ff <= extra_feature_control_ff;
        `UEFG_A_DLL:      reg_rdata_ff <= dll_ff;
        `UEFG_A_DLM:      reg_rdata_ff <= dlm_ff;
        `UEFG_A_DLD:      reg_rdata_ff <= dld_ff;
        `UEFG_A_EFR:      reg_rdata_ff <= efr_ff;
        default:          reg_rdata_ff <= 8'h00;
      endcase
    end
  end
endmodule // uefg_core
`default_nettype wire

/* tb/uefg_checker.sv */
// checker: port-level assertions for uefg_core
// assumes a bind onto uefg_core with ports by name
`timescale 1ns/100ps
`default_nettype none
module uefg_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [4:0]  reg_index,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [3:0]  gpio_oe_ff,
  input wire logic [3:0]  gpio_out_ff,
  input wire logic        tx_run_ff,
  input wire logic        rx_run_ff,
  input wire logic        tx_char_active,
  input wire logic        rx_char_active,
  input wire logic [1:0]  tx_flow_sel_ff,
  input wire logic [1:0]  rx_flow_sel_ff,
  input wire logic        soft_reset_ff,
  input wire logic        irq_n_ff,
  input wire logic [15:0] divisor_int_ff
);
  // ==========================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // a write landing on the soft reset pulse may be wiped, so skip it
  wire wr_ok = reg_wr && !soft_reset_ff;
  property p_srst_set; wr_ok && reg_index == 5'h0e && reg_wdata[3] |=> soft_reset_ff; endproperty
  a_srst_set: assert property (p_srst_set) else $error("soft reset not raised");
  property p_srst_clr; soft_reset_ff |=> !soft_reset_ff; endproperty
  a_srst_clr: assert property (p_srst_clr) else $error("soft reset stuck");
  property p_dir; wr_ok && reg_index == 5'h0a |=> ##1 gpio_oe_ff == $past(reg_wdata[3:0], 2); endproperty
  a_dir: assert property (p_dir) else $error("pin enables wrong");
  property p_out; wr_ok && reg_index == 5'h0b |=> ##1 gpio_out_ff == $past(reg_wdata[3:0], 2); endproperty
  a_out: assert property (p_out) else $error("pin outputs wrong");
  property p_flow;
    wr_ok && reg_index == 5'h13 |=> ##1 {tx_flow_sel_ff, rx_flow_sel_ff} == $past(reg_wdata[3:0], 2);
  endproperty
  a_flow: assert property (p_flow) else $error("flow select wrong");
  property p_txdis; $fell(tx_run_ff) |-> !$past(tx_char_active); endproperty
  a_txdis: assert property (p_txdis) else $error("tx stopped mid character");
  property p_rxdis;
    wr_ok && reg_index == 5'h0f && reg_wdata[1] |=> ##1 (!rx_run_ff || $past(rx_char_active));
  endproperty
  a_rxdis: assert property (p_rxdis) else $error("rx not stopped");
  property p_rst;
    @(posedge clk) disable iff (1'b0) reset |=> irq_n_ff && divisor_int_ff == 16'h0001;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_srst: cover property (soft_reset_ff);
  c_irq: cover property ($fell(irq_n_ff));
  c_txdis: cover property ($fell(tx_run_ff));
endmodule // uefg_checker
`default_nettype wire

/* tb/uefg_pins.sv */
// partner: the four gpio pins with the world outside
// assumes registered enable and output from the core
`timescale 1ns/100ps
`default_nettype none
module uefg_pins (
  input  wire logic [3:0] oe,
  input  wire logic [3:0] out,
  input  wire logic [3:0] ext,
  output logic      [3:0] pin
);
  // a driven pin shows the core's level, an input pin the outside level
  assign pin = (oe & out) | (~oe & ext);
endmodule // uefg_pins
`default_nettype wire

/* tb/test_uefg_core.sv */
// testbench for uefg_core: register port, fifo events, gpio pins
// assumes uefg_core, uefg_pins and uefg_checker compiled before it
`timescale 1ns/100ps
`default_nettype none
module test_uefg_core;
  logic        clk, reset, reg_wr, reg_rd, tx_push, tx_pop, rx_push, rx_pop, baud_tick, zero, rd_seen;
  logic [4:0]  idx;
  logic [7:0]  wd;
  logic [3:0]  ext;
  wire  [7:0]  rdata;
  wire  [3:0]  gin, gout, goe, fr;
  wire  [1:0]  sm, tf, rf;
  wire  [15:0] dv;
  wire         txr, rxr, rxt, irqn, txrun, rxrun, srst;
  int          failures = 0, cmp_count = 0, cyc = 0, n, f;
  logic [15:0] q[$];
  uefg_core dut_u (.clk(clk), .reset(reset), .reg_index(idx), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(wd), .reg_rdata_ff(rdata), .tx_push(tx_push), .tx_pop(tx_pop), .rx_push(rx_push),
    .rx_pop(rx_pop), .rx_line_busy(zero), .tx_char_active(zero), .rx_char_active(zero),
    .baud_tick(baud_tick), .gpio_in(gin), .gpio_out_ff(gout), .gpio_oe_ff(goe), .tx_ready_irq_ff(txr),
    .rx_ready_irq_ff(rxr), .rx_timeout_irq_ff(rxt), .irq_n_ff(irqn), .tx_run_ff(txrun), .rx_run_ff(rxrun),
    .divisor_int_ff(dv), .divisor_frac_ff(fr), .sample_mode_ff(sm), .tx_flow_sel_ff(tf),
    .rx_flow_sel_ff(rf), .soft_reset_ff(srst));
  uefg_pins pins_u (.oe(goe), .out(gout), .ext(ext), .pin(gin));
  // ==========================================
  // shared tasks
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] i, input logic [7:0] d);
    @(posedge clk); reg_wr <= w; reg_rd <= !w; idx <= i; wd <= d;
    @(posedge clk); reg_wr <= 1'b0; reg_rd <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] d); acc(1'b1, i, d); endtask
  // the mask hides bits whose read value is left open
  task automatic rd(input logic [4:0] i, input logic [7:0] m, input logic [7:0] e);
    q.push_back({m, e});
    acc(1'b0, i, 8'h00);
  endtask
  task automatic run(input logic [4:0] s, input int k);
    repeat (k) begin @(posedge clk); {tx_push, tx_pop, rx_push, rx_pop, baud_tick} <= s; end
    @(posedge clk); {tx_push, tx_pop, rx_push, rx_pop, baud_tick} <= 5'h00;
  endtask
  // settle past the edge so registered outputs are read after they update
  task automatic waitn(input int k); repeat (k) @(posedge clk); #1; endtask
  task final_report;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin clk = 1'b0; forever #50 clk = ~clk; end
  always @(posedge clk) begin
    if (rd_seen && q.size() > 0) begin
      check("rdata", {8'h00, rdata & q[0][15:8]}, {8'h00, q[0][7:0]});
      void'(q.pop_front());
    end
    rd_seen <= reg_rd;
    cyc++;
    if (cyc > 20000) begin failures++; final_report(); end
  end
  // ==========================================
  // scenarios
  initial begin
    reset = 1'b1; {reg_wr, reg_rd, tx_push, tx_pop, rx_push, rx_pop, baud_tick, zero, rd_seen} = 9'h000;
    idx = 5'h00; wd = 8'h00; ext = 4'h0;
    void'($urandom(26112));
    waitn(2); reset <= 1'b0;
    rd(5'h08, 8'hff, 8'h40); rd(5'h09, 8'hff, 8'h00); rd(5'h07, 8'hff, 8'hff);
    wr(5'h12, 8'h15); waitn(1); check("frac", fr, 0);
    wr(5'h13, 8'h10); wr(5'h12, 8'h15); wr(5'h00, 8'h34); wr(5'h01, 8'h12); waitn(1);
    check("frac", fr, 5); check("mode", sm, 1); check("div", dv, 16'h1234);
    wr(5'h12, 8'h25); waitn(1); check("mode", sm, 2);
    f = $urandom_range(15, 1); n = $urandom_range(64, 1);
    wr(5'h04, 8'h04); wr(5'h07, {f[3:0], f[3:0]});
    run(5'b00100, n); waitn(3); rd(5'h09, 8'hff, n[7:0]);
    check("rxrdy", rxr, n >= 4 * f); check("txrdy", txr, 1);
    run(5'b10000, 65); waitn(3); rd(5'h08, 8'hff, 8'h00); check("txrdy", txr, 0);
    run(5'b01000, 4 * f - 1); waitn(3); check("txrdy", txr, 0);
    run(5'b01000, 1); waitn(3); check("txrdy", txr, 1);
    wr(5'h02, 8'hf0); wr(5'h07, 8'h00); waitn(3);
    check("rxrdy", rxr, n >= 60); check("txrdy", txr, 4 * f >= 56);
    check("tmo", rxt, 0); run(5'b00001, 39); waitn(3); check("tmo", rxt, 0);
    run(5'b00001, 1); waitn(3); check("tmo", rxt, 1);
    run(5'b00010, 65); run(5'b01000, 65); rd(5'h09, 8'hff, 8'h00);
    wr(5'h0f, 8'h04); waitn(1); check("txrun", txrun, 0); check("rxrun", rxrun, 1);
    run(5'b10000, 1); waitn(2); rd(5'h08, 8'hff, 8'h3f);
    wr(5'h0f, 8'h02); waitn(1); check("txrun", txrun, 1); check("rxrun", rxrun, 0);
    wr(5'h0f, 8'h00);
    wr(5'h0a, 8'h25); waitn(1); check("oe", goe, 5);
    wr(5'h0b, 8'h0a); waitn(1); check("out", gout, 4'ha); ext <= 4'ha; waitn(4);
    rd(5'h0b, 8'h0f, 8'h0a);
    wr(5'h0a, 8'h20); wr(5'h0c, 8'h0d); wr(5'h0e, 8'h02); waitn(6); rd(5'h0b, 8'h0f, 8'h0a);
    ext <= 4'h8; waitn(6); check("irq", irqn, 1); ext <= 4'ha; waitn(6);
    ext <= 4'hb; waitn(6); check("irq", irqn, 0); ext <= 4'ha; waitn(6); check("irq", irqn, 1);
    ext <= 4'hb; waitn(6); rd(5'h0b, 8'h0f, 8'h0b); waitn(4); check("irq", irqn, 1);
    wr(5'h0e, 8'h03); ext <= 4'ha; waitn(6); ext <= 4'hb; waitn(6); check("irq", irqn, 0);
    rd(5'h0b, 8'h01, 8'h00); waitn(4); check("irq", irqn, 1);
    wr(5'h0e, 8'h0a); waitn(2); rd(5'h0a, 8'hff, 8'h00); rd(5'h00, 8'hff, 8'h34);
    rd(5'h0e, 8'h08, 8'h00); rd(5'h1f, 8'hff, 8'h00);
    for (int k = 0; k < 16; k++) begin
      wr(5'h13, 8'h10); wr(5'h13, 8'h10 | k[7:0]); waitn(1);
      check("flow", {tf, rf}, k[3:0]);
    end
    waitn(2);
    final_report();
  end
endmodule // test_uefg_core
bind uefg_core uefg_checker chk_u (.clk(clk), .reset(reset), .reg_index(reg_index), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .gpio_oe_ff(gpio_oe_ff), .gpio_out_ff(gpio_out_ff), .tx_run_ff(tx_run_ff),
  .rx_run_ff(rx_run_ff), .tx_char_active(tx_char_active), .rx_char_active(rx_char_active),
  .tx_flow_sel_ff(tx_flow_sel_ff), .rx_flow_sel_ff(rx_flow_sel_ff), .soft_reset_ff(soft_reset_ff),
  .irq_n_ff(irq_n_ff), .divisor_int_ff(divisor_int_ff));
`default_nettype wire
